/* File: inc/cpualu_cfg.svh */
`ifndef CPUALU_CFG_SVH
`define CPUALU_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CPUALU_CTL_OFS 4'h0
`define CPUALU_SR_OFS 4'h4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CPUALU_CTL_PRIORITY_MSB_FLAG 3
`define CPUALU_CTL_PSV 2
`define CPUALU_SR_DC 8
`define CPUALU_SR_N 3
`define CPUALU_SR_OV 2
`define CPUALU_SR_Z 1
`define CPUALU_SR_C 0
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define CPUALU_DIV_CYCLES 5'h10
`define CPUALU_DIV_LAST 5'h01
`endif

/* File: inc/cpualu_pkg.sv */
package cpualu_pkg;
    typedef enum logic [3:0] {
        OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR,
        OP_ASR, OP_SL, OP_LSR, OP_MUL, OP_DIV
    } cpualu_op_t;
    typedef enum logic [2:0] {
        MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_U8
    } cpualu_mul_t;
    typedef enum logic {DIV_IDLE, DIV_RUN} cpualu_dst_t;
    typedef struct packed {
        cpualu_dst_t state;
        logic [4:0] cnt;
        logic [15:0] rem;
        logic [15:0] quo;
        logic [15:0] dvs;
        logic neg_q;
        logic neg_r;
        logic done;
    } cpualu_div_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic priority_msb_flag;
        logic program_space_window_enable;
        logic dc;
        logic [2:0] cpu_priority_level;
        logic n;
        logic ov;
        logic z;
        logic c;
        logic busy;
        logic rvalid;
        logic [15:0] rdata;
        logic [15:0] rhi;
        logic rmem;
        logic rbyte;
        logic rdiv;
        logic err;
    } cpualu_top_t;
endpackage : cpualu_pkg

/* File: src/cpualu_div.sv */
`include "cpualu_cfg.svh"
module cpualu_div
    import cpualu_pkg::*;
(
    input logic clk_i,
    input logic rst_i,
    input logic start_i,
    input logic sgn_i,
    input logic long_i,
    input logic [15:0] hi_i,
    input logic [15:0] lo_i,
    input logic [15:0] dvs_i,
    output logic done_o,
    output logic [15:0] quo_o,
    output logic [15:0] rem_o
);
    cpualu_div_t s_r;
    cpualu_div_t s_nxt;
    logic [31:0] dvd;
    logic [31:0] mag;
    logic [15:0] dmag;
    logic [17:0] trial;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        dvd = long_i ? {hi_i, lo_i} : {(sgn_i ? {16{lo_i[15]}} : 16'h0000), lo_i};
        mag = (sgn_i && dvd[31]) ? 32'(-dvd) : dvd;
        dmag = (sgn_i && dvs_i[15]) ? 16'(-dvs_i) : dvs_i;
        trial = {1'b0, s_r.rem, s_r.quo[15]} - {2'b00, s_r.dvs};
        case (s_r.state)
            DIV_IDLE:
            begin
                if (start_i)
                begin
                    s_nxt.state = DIV_RUN;
                    s_nxt.cnt = `CPUALU_DIV_CYCLES;
                    s_nxt.rem = mag[31:16];
                    s_nxt.quo = mag[15:0];
                    s_nxt.dvs = dmag;
                    s_nxt.neg_q = sgn_i && (dvd[31] ^ dvs_i[15]);
                    s_nxt.neg_r = sgn_i && dvd[31];
                end
            end
            DIV_RUN:
            begin
                if (!trial[17])
                begin
                    s_nxt.rem = trial[15:0];
                    s_nxt.quo = {s_r.quo[14:0], 1'b1};
                end
                else
                begin
                    s_nxt.rem = {s_r.rem[14:0], s_r.quo[15]};
                    s_nxt.quo = {s_r.quo[14:0], 1'b0};
                end
                s_nxt.cnt = s_r.cnt - 5'h01;
                if (s_r.cnt == `CPUALU_DIV_LAST)
                begin
                    s_nxt.state = DIV_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
            default: s_nxt.state = DIV_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign done_o = s_r.done;
    assign quo_o = s_r.neg_q ? 16'(-s_r.quo) : s_r.quo;
    assign rem_o = s_r.neg_r ? 16'(-s_r.rem) : s_r.rem;
endmodule : cpualu_div

/* File: src/cpualu_mul.sv */
module cpualu_mul
    import cpualu_pkg::*;
(
    input logic [15:0] a_i,
    input logic [15:0] b_i,
    input logic [4:0] lit_i,
    input cpualu_mul_t mode_i,
    output logic [31:0] prod_o
);
    logic signed [16:0] xa;
    logic signed [16:0] xb;
    logic signed [33:0] full;

    // One shared 17x17 array; the extra bit carries sign or zero
    always_comb
    begin
        xa = {1'b0, a_i};
        xb = {1'b0, b_i};
        case (mode_i)
            MUL_SS:
            begin
                xa = {a_i[15], a_i};
                xb = {b_i[15], b_i};
            end
            MUL_SU: xa = {a_i[15], a_i};
            MUL_US: xb = {b_i[15], b_i};
            MUL_SLIT:
            begin
                xa = {a_i[15], a_i};
                xb = {12'h000, lit_i};
            end
            MUL_ULIT: xb = {12'h000, lit_i};
            MUL_U8:
            begin
                xa = {9'h000, a_i[7:0]};
                xb = {9'h000, b_i[7:0]};
            end
            default: xa = {1'b0, a_i};
        endcase
        full = xa * xb;
    end

    assign prod_o = full[31:0];
endmodule : cpualu_mul

/* File: src/cpualu_top.sv */
// Notes on behaviour
// - Priority MSB flag: bit 3, hardware set/clear
// - Flag set blocks all user interrupts
// - Bit 2 maps program space into data
// - Other control bits read as zero
// - 16-bit two's complement add, sub, logic
// - Add and sub update C, Z, N, OV, DC; logic and shifts N, Z
// - Subtract: C and DC mean no-borrow
// - Byte or word operand size
// - Operand and result: register or memory
// - Shared 17x17 multiplier array
// - Seven signedness multiply modes
// - Signed/unsigned 32/16 and 16/16 divide
// - Quotient to register zero, remainder one
// - Long dividend from aligned register pair
// - One cycle per divisor bit
// - Shift up to 15 bits in one cycle
// - Multi-bit shifts register-direct only
// - Arithmetic right, left, logical right shifts
// - Priority level is MSB flag plus status field
// - Half carry from bit 4 or bit 8
// - Carry from result MSB
`include "cpualu_cfg.svh"
module cpualu_top
    import cpualu_pkg::*;
(
    input logic SYS_CLK_I,
    input logic SRST_I,
    input logic [3:0] ADR_I,
    input logic [31:0] DAT_I,
    input logic [3:0] SEL_I,
    input logic WE_I,
    input logic CYC_I,
    input logic STB_I,
    output logic ACK_O,
    output logic [31:0] DAT_O,
    input logic OP_VALID_I,
    input cpualu_op_t OP_CODE_I,
    input logic OP_BYTE_I,
    input logic OP_SRC_MEM_I,
    input logic OP_DST_MEM_I,
    input logic [15:0] OP_A_I,
    input logic [15:0] OP_MEM_I,
    input logic [15:0] OP_B_I,
    input logic [15:0] OP_HI_I,
    input logic [4:0] OP_LIT_I,
    input cpualu_mul_t OP_MUL_MODE_I,
    input logic OP_SIGNED_I,
    input logic OP_LONG_I,
    input logic PRIORITY_MSB_FLAG_SET_I,
    input logic PRIORITY_MSB_FLAG_CLR_I,
    output logic BUSY_O,
    output logic RES_VALID_O,
    output logic [15:0] RES_DATA_O,
    output logic [15:0] RES_HI_O,
    output logic RES_TO_MEM_O,
    output logic RES_BYTE_O,
    output logic RES_DIV_O,
    output logic ERR_O,
    output logic USER_IRQ_BLOCK_O,
    output logic PSV_EN_O,
    output logic [3:0] IPL_O
);
    cpualu_top_t s_r;
    cpualu_top_t s_nxt;
    logic acc;
    logic wb;
    logic shop;
    logic rej;
    logic sub;
    logic [15:0] opa;
    logic [15:0] ea;
    logic [15:0] eb;
    logic [15:0] bb;
    logic [16:0] sum;
    logic [16:0] cx;
    logic [15:0] res;
    logic [31:0] rd;
    logic [31:0] prod;
    logic div_done;
    logic [15:0] div_quo;
    logic [15:0] div_rem;

    // ----------------------------------------
    // Operand selection
    // ----------------------------------------
    // Divider holds the pipeline, so new work waits for it
    assign acc = OP_VALID_I && !s_r.busy;
    assign wb = CYC_I && STB_I && !s_r.ack;
    assign shop = OP_CODE_I == OP_ASR || OP_CODE_I == OP_SL || OP_CODE_I == OP_LSR;
    assign rej = acc && shop && OP_LIT_I[3:1] != 3'h0 && (OP_SRC_MEM_I || OP_DST_MEM_I);
    assign sub = OP_CODE_I == OP_SUB;
    assign opa = OP_SRC_MEM_I ? OP_MEM_I : OP_A_I;

    // ----------------------------------------
    // Multiplier and divider
    // ----------------------------------------
    // shared multiply array
    cpualu_mul u_mul
    (
        .a_i(opa),
        .b_i(OP_B_I),
        .lit_i(OP_LIT_I),
        .mode_i(OP_MUL_MODE_I),
        .prod_o(prod)
    );

    cpualu_div u_div
    (
        .clk_i(SYS_CLK_I),
        .rst_i(SRST_I),
        .start_i(acc && OP_CODE_I == OP_DIV),
        .sgn_i(OP_SIGNED_I),
        .long_i(OP_LONG_I),
        .hi_i(OP_HI_I),
        .lo_i(OP_A_I),
        .dvs_i(OP_B_I),
        .done_o(div_done),
        .quo_o(div_quo),
        .rem_o(div_rem)
    );

    // ----------------------------------------
    // Adder and logic
    // ----------------------------------------
    always_comb
    begin
        ea = OP_BYTE_I ? {8'h00, opa[7:0]} : opa;
        eb = OP_BYTE_I ? {8'h00, OP_B_I[7:0]} : OP_B_I;
        bb = sub ? ~eb : eb;
        sum = {1'b0, ea} + {1'b0, bb} + {16'h0000, sub};
        // Carry into each bit, valid whatever the upper byte holds
        cx = {1'b0, ea} ^ {1'b0, bb} ^ sum;
        case (OP_CODE_I)
            OP_ADD: res = sum[15:0];
            OP_SUB: res = sum[15:0];
            OP_AND: res = ea & eb;
            OP_IOR: res = ea | eb;
            OP_XOR: res = ea ^ eb;
            OP_ASR: res = 16'($signed(opa) >>> OP_LIT_I[3:0]);
            OP_SL: res = opa << OP_LIT_I[3:0];
            OP_LSR: res = opa >> OP_LIT_I[3:0];
            default: res = prod[15:0];
        endcase
    end

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    always_comb
    begin
        case (ADR_I)
            `CPUALU_CTL_OFS: rd = {28'h0000000, s_r.priority_msb_flag, s_r.program_space_window_enable, 2'b00};
            `CPUALU_SR_OFS: rd = {23'h000000, s_r.dc, s_r.cpu_priority_level, 1'b0, s_r.n, s_r.ov, s_r.z, s_r.c};
            default: rd = 32'h00000000;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = wb;
        s_nxt.rvalid = 1'b0;
        s_nxt.err = 1'b0;
        if (wb && !WE_I)
        begin
            s_nxt.dat = rd;
        end
        if (wb && WE_I && SEL_I[0] && ADR_I == `CPUALU_CTL_OFS)
        begin
            s_nxt.program_space_window_enable = DAT_I[`CPUALU_CTL_PSV];
            if (!DAT_I[`CPUALU_CTL_PRIORITY_MSB_FLAG])
            begin
                s_nxt.priority_msb_flag = 1'b0;
            end
        end
        if (wb && WE_I && ADR_I == `CPUALU_SR_OFS)
        begin
            if (SEL_I[1])
            begin
                s_nxt.dc = DAT_I[`CPUALU_SR_DC];
            end
            if (SEL_I[0])
            begin
                s_nxt.cpu_priority_level = DAT_I[7:5];
                s_nxt.n = DAT_I[`CPUALU_SR_N];
                s_nxt.ov = DAT_I[`CPUALU_SR_OV];
                s_nxt.z = DAT_I[`CPUALU_SR_Z];
                s_nxt.c = DAT_I[`CPUALU_SR_C];
            end
        end
        // hardware set wins over any clear
        if (PRIORITY_MSB_FLAG_CLR_I)
        begin
            s_nxt.priority_msb_flag = 1'b0;
        end
        if (PRIORITY_MSB_FLAG_SET_I)
        begin
            s_nxt.priority_msb_flag = 1'b1;
        end
        // Flag updates from the datapath beat a same-cycle software write
        if (rej)
        begin
            s_nxt.err = 1'b1;
        end
        else if (acc && OP_CODE_I == OP_DIV)
        begin
            s_nxt.busy = 1'b1;
        end
        else if (acc)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = res;
            s_nxt.rhi = prod[31:16];
            s_nxt.rmem = OP_DST_MEM_I;
            s_nxt.rbyte = OP_BYTE_I && OP_CODE_I != OP_MUL && !shop;
            s_nxt.rdiv = 1'b0;
            if (OP_CODE_I != OP_MUL)
            begin
                s_nxt.n = s_nxt.rbyte ? res[7] : res[15];
                s_nxt.z = s_nxt.rbyte ? res[7:0] == 8'h00 : res == 16'h0000;
            end
            if (OP_CODE_I == OP_ADD || sub)
            begin
                s_nxt.c = OP_BYTE_I ? cx[8] : sum[16];
                s_nxt.dc = OP_BYTE_I ? cx[4] : cx[8];
                s_nxt.ov = OP_BYTE_I ? cx[7] ^ cx[8] : cx[15] ^ sum[16];
            end
        end
        if (div_done)
        begin
            s_nxt.busy = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = div_quo;
            s_nxt.rhi = div_rem;
            s_nxt.rmem = 1'b0;
            s_nxt.rbyte = 1'b0;
            s_nxt.rdiv = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (SRST_I)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign ACK_O = s_r.ack;
    assign DAT_O = s_r.dat;
    assign BUSY_O = s_r.busy;
    assign RES_VALID_O = s_r.rvalid;
    assign RES_DATA_O = s_r.rdata;
    assign RES_HI_O = s_r.rhi;
    assign RES_TO_MEM_O = s_r.rmem;
    assign RES_BYTE_O = s_r.rbyte;
    assign RES_DIV_O = s_r.rdiv;
    assign ERR_O = s_r.err;
    assign USER_IRQ_BLOCK_O = s_r.priority_msb_flag;
    assign PSV_EN_O = s_r.program_space_window_enable;
    assign IPL_O = {s_r.priority_msb_flag, s_r.cpu_priority_level};

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [16:0] add_ref;
    logic [15:0] asr_ref;
    logic [31:0] mul_ref;
    logic du;
    logic wreg;
    assign wreg = acc && !OP_SRC_MEM_I && !OP_BYTE_I && !rej;
    assign add_ref = {1'b0, OP_A_I} + {1'b0, OP_B_I};
    assign asr_ref = 16'($signed(OP_A_I) >>> OP_LIT_I[3:0]);
    assign mul_ref = {16'h0000, OP_A_I} * {16'h0000, OP_B_I};
    assign du = acc && OP_CODE_I == OP_DIV && !OP_SIGNED_I && !OP_LONG_I && OP_B_I != 16'h0000;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SRST_I);

    sequence s_div_go;
        acc && OP_CODE_I == OP_DIV;
    endsequence
    sequence s_div_wait;
        BUSY_O[*8] ##1 BUSY_O[*8] ##1 BUSY_O ##1 (RES_VALID_O && RES_DIV_O && !BUSY_O);
    endsequence

    AST_PRIORITY_MSB_FLAG_SET: assert property (PRIORITY_MSB_FLAG_SET_I |=> USER_IRQ_BLOCK_O && IPL_O[3])
        else $error("priority flag not set");
    AST_CTL_ZERO: assert property (ACK_O && !$past(WE_I) && $past(ADR_I) == `CPUALU_CTL_OFS |-> DAT_O[31:4] == 28'h0000000 && DAT_O[1:0] == 2'b00)
        else $error("reserved control bits nonzero");
    AST_PSV_WR: assert property (wb && WE_I && SEL_I[0] && ADR_I == `CPUALU_CTL_OFS |=> PSV_EN_O == $past(DAT_I[2]))
        else $error("window enable not written");
    AST_ADD_C: assert property (wreg && OP_CODE_I == OP_ADD |=> s_r.c == $past(add_ref[16]) && RES_DATA_O == $past(add_ref[15:0]))
        else $error("add carry or sum wrong");
    AST_SUB_C: assert property (wreg && sub |=> s_r.c == ($past(OP_A_I) >= $past(OP_B_I)))
        else $error("borrow wrong");
    AST_DIV_TIME: assert property (s_div_go |=> s_div_wait)
        else $error("divide timing wrong");
    AST_DIV_VAL: assert property (RES_VALID_O && RES_DIV_O && $past(du, 18) |-> RES_DATA_O == $past(OP_A_I, 18) / $past(OP_B_I, 18) && RES_HI_O == $past(OP_A_I, 18) % $past(OP_B_I, 18))
        else $error("divide result wrong");
    AST_ASR: assert property (wreg && OP_CODE_I == OP_ASR |=> RES_VALID_O && RES_DATA_O == $past(asr_ref))
        else $error("arithmetic shift wrong");
    AST_SH_REJ: assert property (rej |=> ERR_O && !RES_VALID_O)
        else $error("memory shift not refused");
    AST_MUL_UU: assert property (wreg && OP_CODE_I == OP_MUL && OP_MUL_MODE_I == MUL_UU |=> {RES_HI_O, RES_DATA_O} == $past(mul_ref))
        else $error("unsigned product wrong");
endmodule : cpualu_top

/* File: tb/cpualu_top_tb.sv */
`include "cpualu_cfg.svh"
module cpualu_top_tb
    import cpualu_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, we, cyc, stb, ack, opv, iset, iclr, obyte, osm, odm, osg, olg;
    logic busy, rv, rto, rby, rdv, err, blk, program_space_window_enable;
    logic [3:0] adr, sel, cpu_priority_level;
    logic [31:0] wdat, rdat, q, f;
    logic [15:0] oa, om, ob, oh, rd, rh, w0, w1, a, b, h, m;
    logic [4:0] olit, fl;
    cpualu_op_t opc, rop;
    cpualu_mul_t omode;
    integer seed = 32'h2ae3e128;
    int miscompares = 0;
    int n_compared = 0;
    int i, k;

    cpualu_top cpualu_top_i (
        .SYS_CLK_I(clk), .SRST_I(srst), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .WE_I(we),
        .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .DAT_O(rdat), .OP_VALID_I(opv), .OP_CODE_I(opc),
        .OP_BYTE_I(obyte), .OP_SRC_MEM_I(osm), .OP_DST_MEM_I(odm), .OP_A_I(oa), .OP_MEM_I(om),
        .OP_B_I(ob), .OP_HI_I(oh), .OP_LIT_I(olit), .OP_MUL_MODE_I(omode), .OP_SIGNED_I(osg),
        .OP_LONG_I(olg), .PRIORITY_MSB_FLAG_SET_I(iset), .PRIORITY_MSB_FLAG_CLR_I(iclr), .BUSY_O(busy), .RES_VALID_O(rv),
        .RES_DATA_O(rd), .RES_HI_O(rh), .RES_TO_MEM_O(rto), .RES_BYTE_O(rby), .RES_DIV_O(rdv),
        .ERR_O(err), .USER_IRQ_BLOCK_O(blk), .PSV_EN_O(program_space_window_enable), .IPL_O(cpu_priority_level)
    );
    cpualu_wreg_model cpualu_wreg_model_i (
        .clk_i(clk), .rst_i(srst), .res_valid_i(rv), .res_div_i(rdv), .res_data_i(rd),
        .res_hi_i(rh), .w0_o(w0), .w1_o(w1)
    );

    // ----------------------------------------
    // Expected values
    // ----------------------------------------
    function automatic logic [20:0] f_alu(input cpualu_op_t op, input logic byt, input logic [15:0] x,
        input logic [15:0] y, input logic [3:0] s, input logic [4:0] p);
        logic [16:0] t, u;
        logic [15:0] mk, r, z;
        logic c, d, v;
        int j;
        mk = byt ? 16'h00FF : 16'hFFFF;
        j = byt ? 7 : 15;
        z = (op == OP_SUB) ? ~y : y;
        t = {1'b0, x & mk} + {1'b0, z & mk} + 17'(op == OP_SUB);
        // Low nibble or low byte only, so bit 4 or 8 is the digit carry
        u = {1'b0, x & (mk >> (byt ? 4 : 8))} + {1'b0, z & (mk >> (byt ? 4 : 8))} + 17'(op == OP_SUB);
        c = t[j + 1];
        d = byt ? u[4] : u[8];
        v = (x[j] == z[j]) && (t[j] != x[j]);
        case (op)
            OP_AND: r = x & y;
            OP_IOR: r = x | y;
            OP_XOR: r = x ^ y;
            OP_ASR: r = 16'($signed(x) >>> s);
            OP_SL: r = x << s;
            OP_LSR: r = x >> s;
            default: r = t[15:0];
        endcase
        r = r & mk;
        // Logic and shift ops keep C, OV, DC
        if (op == OP_ADD || op == OP_SUB)
            return {d, r[j], v, r == 16'h0000, c, r};
        return {p[4], r[j], p[2], r == 16'h0000, p[0], r};
    endfunction : f_alu

    function automatic logic [31:0] f_mul(input cpualu_mul_t md, input logic [15:0] x, input logic [15:0] y,
        input logic [4:0] l);
        longint p, r;
        p = (md inside {MUL_SS, MUL_SU, MUL_SLIT}) ? longint'($signed(x)) : longint'(x);
        r = (md inside {MUL_SS, MUL_US}) ? longint'($signed(y)) : longint'(y);
        if (md inside {MUL_SLIT, MUL_ULIT})
            r = longint'(l);
        if (md == MUL_U8)
        begin
            p = longint'(x[7:0]);
            r = longint'(y[7:0]);
        end
        return 32'(p * r);
    endfunction : f_mul

    function automatic logic [31:0] f_div(input logic sg, input logic lg, input logic [15:0] hi,
        input logic [15:0] lo, input logic [15:0] y);
        longint p, r;
        p = lg ? longint'({hi, lo}) : longint'(lo);
        r = longint'(y);
        if (sg)
        begin
            p = lg ? longint'($signed({hi, lo})) : longint'($signed(lo));
            r = longint'($signed(y));
        end
        return {16'(p % r), 16'(p / r)};
    endfunction : f_div

    // ----------------------------------------
    // Checks and bus tasks
    // ----------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic report_and_stop();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic wb(input logic [3:0] ad, input logic w, input logic [15:0] d);
        int j;
        adr <= ad;
        we <= w;
        wdat <= {16'h0000, d};
        sel <= 4'hF;
        cyc <= 1'b1;
        stb <= 1'b1;
        for (j = 0; j < 20; j++)
        begin
            @(posedge clk);
            if (ack === 1'b1)
                break;
        end
        q = rdat;
        chk_bit(ack, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic rd_chk(input logic [3:0] ad, input logic [15:0] e);
        wb(ad, 1'b0, 16'h0000);
        chk_val({16'h0000, q[15:0]}, {16'h0000, e});
    endtask : rd_chk

    task automatic pulse(input logic s, input logic c);
        iset <= s;
        iclr <= c;
        @(posedge clk);
        iset <= 1'b0;
        iclr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse

    // Flags word: [0] byte, [1] src mem, [2] dst mem, [3] signed, [4] long
    task automatic op_chk(input cpualu_op_t op, input logic [4:0] fg, input logic [15:0] x,
        input logic [15:0] mv, input logic [15:0] y, input logic [15:0] hi, input logic [4:0] lit,
        input cpualu_mul_t md);
        logic [15:0] d, hr, src, mk;
        logic e, t, by, dv, xe;
        logic [20:0] ex;
        logic [31:0] dq;
        int n, nb;
        src = fg[1] ? mv : x;
        mk = fg[0] ? 16'h00FF : 16'hFFFF;
        xe = (op inside {OP_ASR, OP_SL, OP_LSR}) && lit[3:0] > 4'h1 && fg[2:1] != 2'b00;
        {olg, osg, odm, osm, obyte} <= fg;
        opc <= op;
        oa <= x;
        om <= mv;
        ob <= y;
        oh <= hi;
        olit <= lit;
        omode <= md;
        opv <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge clk);
            if (busy === 1'b0)
                break;
        end
        opv <= 1'b0;
        nb = 0;
        for (n = 1; n < 40; n++)
        begin
            @(posedge clk);
            if (busy === 1'b1)
                nb++;
            if (rv === 1'b1 || err === 1'b1)
                break;
        end
        {d, hr, e, t, by, dv} = {rd, rh, err, rto, rby, rdv};
        chk_bit(e, xe);
        if (!xe)
        begin
            chk_bit(t, fg[2]);
            chk_bit(dv, op == OP_DIV);
            if (op == OP_MUL)
                chk_val({hr, d}, f_mul(md, src, y, lit));
            else if (op == OP_DIV)
            begin
                dq = f_div(fg[3], fg[4], hi, x, y);
                chk_val({hr, d}, dq);
                chk_val(32'(n), 32'h00000012);
                chk_val(32'(nb), 32'h00000011);
                @(posedge clk);
                chk_val({w1, w0}, dq);
            end
            else
            begin
                ex = f_alu(op, fg[0], src, y, lit[3:0], fl);
                chk_val({16'h0000, d & mk}, {16'h0000, ex[15:0]});
                chk_bit(by, fg[0]);
                fl = ex[20:16];
            end
        end
        wb(`CPUALU_SR_OFS, 1'b0, 16'h0000);
        chk_val(q & 32'h0000010F, {23'h000000, fl[4], 4'h0, fl[3:0]});
    endtask : op_chk

    // ----------------------------------------
    // Clock, watchdog, sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Ops average under 30 cycles; generous margin
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        srst = 1'b1;
        {we, cyc, stb, opv, iset, iclr, obyte, osm, odm, osg, olg} = '0;
        {adr, sel, wdat, oa, om, ob, oh, olit} = '0;
        opc = OP_ADD;
        omode = MUL_SS;
        fl = 5'h00;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk(`CPUALU_CTL_OFS, 16'h0000);
        wr_ctl: wb(`CPUALU_CTL_OFS, 1'b1, 16'hFFFF);
        rd_chk(`CPUALU_CTL_OFS, 16'h0004);
        chk_bit(program_space_window_enable, 1'b1);
        pulse(1'b1, 1'b1);
        chk_bit(blk, 1'b1);
        wb(`CPUALU_SR_OFS, 1'b1, 16'h00A0);
        rd_chk(`CPUALU_CTL_OFS, 16'h000C);
        chk_val({28'h0000000, cpu_priority_level}, 32'h0000000D);
        pulse(1'b0, 1'b1);
        chk_bit(blk, 1'b0);
        pulse(1'b1, 1'b0);
        wb(`CPUALU_CTL_OFS, 1'b1, 16'h0000);
        rd_chk(`CPUALU_CTL_OFS, 16'h0000);
        chk_bit(program_space_window_enable, 1'b0);
        chk_val({28'h0000000, cpu_priority_level}, 32'h00000005);
        wb(4'h8, 1'b1, 16'hFFFF);
        rd_chk(4'h8, 16'h0000);
        wb(`CPUALU_SR_OFS, 1'b1, 16'h0000);
        op_chk(OP_ADD, 5'h00, 16'h7FFF, 16'h0000, 16'h0001, 16'h0000, 5'h00, MUL_SS);
        op_chk(OP_SUB, 5'h00, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 5'h00, MUL_SS);
        op_chk(OP_ADD, 5'h03, 16'h1234, 16'h000F, 16'h0001, 16'h0000, 5'h00, MUL_SS);
        op_chk(OP_ADD, 5'h01, 16'h00FF, 16'h0000, 16'h0001, 16'h0000, 5'h00, MUL_SS);
        op_chk(OP_AND, 5'h00, 16'hF0F0, 16'h0000, 16'h0F0F, 16'h0000, 5'h00, MUL_SS);
        op_chk(OP_ASR, 5'h00, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 5'h0F, MUL_SS);
        op_chk(OP_LSR, 5'h00, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 5'h0F, MUL_SS);
        op_chk(OP_SL, 5'h00, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 5'h0F, MUL_SS);
        op_chk(OP_ASR, 5'h04, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 5'h02, MUL_SS);
        op_chk(OP_SL, 5'h02, 16'h0000, 16'h4001, 16'h0000, 16'h0000, 5'h01, MUL_SS);
        op_chk(OP_DIV, 5'h18, 16'hFFF9, 16'h0000, 16'h0002, 16'hFFFF, 5'h00, MUL_SS);
        op_chk(OP_DIV, 5'h00, 16'hFFFF, 16'h0000, 16'h0010, 16'h0000, 5'h00, MUL_SS);
        for (k = 0; k < 7; k++)
            op_chk(OP_MUL, 5'h00, 16'h8001, 16'h0000, 16'hFFFE, 16'h0000, 5'h1F, cpualu_mul_t'(k));
        for (i = 0; i < 200; i++)
        begin
            f = $random(seed);
            a = f[15:0];
            b = f[31:16];
            f = $random(seed);
            h = f[15:0];
            m = f[31:16];
            f = $random(seed);
            rop = cpualu_op_t'(f[31:28] % 10);
            if (rop > OP_XOR)
                f[8] = 1'b0;
            // Divide: no overflow, no zero divisor
            if (rop == OP_DIV)
            begin
                f[10:9] = 2'b00;
                if (b == 16'h0000 || b == 16'hFFFF)
                    b = 16'h0003;
                h = f[11] ? {16{a[15]}} : h % b;
            end
            op_chk(rop, f[12:8], a, m, b, h, f[4:0], cpualu_mul_t'(f[7:5] % 7));
        end
        report_and_stop();
    end
endmodule : cpualu_top_tb

/* File: tb/cpualu_wreg_model.sv */
module cpualu_wreg_model
(
    input logic clk_i,
    input logic rst_i,
    input logic res_valid_i,
    input logic res_div_i,
    input logic [15:0] res_data_i,
    input logic [15:0] res_hi_i,
    output logic [15:0] w0_o,
    output logic [15:0] w1_o
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] w0;
        logic [15:0] w1;
    } cpualu_wreg_t;
    cpualu_wreg_t st_r, st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        if (res_valid_i && res_div_i)
        begin
            st_nxt.w0 = res_data_i;
            st_nxt.w1 = res_hi_i;
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign w0_o = st_r.w0;
    assign w1_o = st_r.w1;
endmodule : cpualu_wreg_model
